// >>> hdl/pidr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pidr_params.svh"

// Overview of operation
// - Size field reads zero: one 4KB block
// - Part number bits 7:0 in low register
// - Part number bits 11:8 in bits 3:0
// - Designer code bits 3:0 in bits 7:4
// - Designer code bits 6:4 in bits 2:0
// - Continuation code in size register bits 3:0
// - Standard identity flag bit always one
// - Fixed revision code in bits 7:4
// - Registers always readable, always present
module pidr_regs #(
   parameter logic [3:0]  CONT_CODE = `PIDR_DEF_CONT,
   parameter logic [6:0]  DESIGNER  = `PIDR_DEF_DESIGNER,
   parameter logic [11:0] PART_NUM  = `PIDR_DEF_PART,
   parameter logic [3:0]  REVISION  = `PIDR_DEF_REVISION
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   pidr_pkg::pidr_req_s   req;
   pidr_pkg::pidr_state_e state;
   pidr_pkg::pidr_state_e next_state;
   logic [7:0]            id_byte;
   logic                  hit;
   logic                  take;
   logic [11:0]           word_addr;

   assign req = '{addr: paddr, write: pwrite, sel: psel, enable: penable};

   // Setup cycle seen while idle
   function automatic logic pidr_setup_seen(
      input pidr_pkg::pidr_state_e st,
      input pidr_pkg::pidr_req_s   rq
   );
      return (st == pidr_pkg::PIDR_IDLE) && rq.sel && !rq.enable;
   endfunction : pidr_setup_seen

   assign take      = pidr_setup_seen(state, req);
   assign word_addr = {paddr[11:2], 2'b00};

   pidr_decode #(
      .CONT_CODE (CONT_CODE),
      .DESIGNER  (DESIGNER),
      .PART_NUM  (PART_NUM),
      .REVISION  (REVISION)
   ) u_decode (
      .addr    ({req.addr[11:2], 2'b00}),
      .id_byte (id_byte),
      .hit     (hit)
   );

   // Setup cycle arms the answer; no wait state in the access phase
   always_comb begin
      next_state = state;
      unique case (state)
         pidr_pkg::PIDR_IDLE: begin
            if (req.sel && !req.enable) begin
               next_state = pidr_pkg::PIDR_ACCESS;
            end
         end
         pidr_pkg::PIDR_ACCESS: begin
            next_state = pidr_pkg::PIDR_IDLE;
         end
         default: begin
            next_state = pidr_pkg::PIDR_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= pidr_pkg::PIDR_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (clk_en) begin
         pready <= take;
      end
   end

   // Reads need no unlock; writes store nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `PIDR_RDATA_RST;
      end else if (clk_en) begin
         if (take && !req.write) begin
            prdata <= {24'h00_0000, id_byte};
         end else begin
            prdata <= `PIDR_RDATA_RST;
         end
      end
   end

   // Unmapped addresses and writes answer with an error, no side effect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pslverr <= take && (req.write || !hit);
      end
   end

   logic unused_ok;
   assign unused_ok = &{1'b0, pwdata, pstrb};

   // Access cycles spent without an answer
   logic [1:0] wait_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 2'h0;
      end else if (clk_en) begin
         if (psel && penable && !pready) begin
            wait_cnt <= wait_cnt + 2'h1;
         end else begin
            wait_cnt <= 2'h0;
         end
      end
   end

   size_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && paddr == `PIDR_OFF_SIZE_DES_HI)
         |-> prdata[7:4] == 4'h0 && prdata[3:0] == CONT_CODE)
      else $error("size or continuation field wrong");

   part_low_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && paddr == `PIDR_OFF_PART_LO)
         |-> prdata[7:0] == PART_NUM[7:0])
      else $error("part number low byte wrong");

   part_high_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && paddr == `PIDR_OFF_PART_HI_DES)
         |-> prdata[3:0] == PART_NUM[11:8])
      else $error("part number high nibble wrong");

   des_low_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && paddr == `PIDR_OFF_PART_HI_DES)
         |-> prdata[7:4] == DESIGNER[3:0])
      else $error("designer low bits wrong");

   des_mid_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && paddr == `PIDR_OFF_DES_MID_REV)
         |-> prdata[2:0] == DESIGNER[6:4])
      else $error("designer middle bits wrong");

   std_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && paddr == `PIDR_OFF_DES_MID_REV)
         |-> prdata[3] == 1'b1)
      else $error("standard identity flag not set");

   revision_code_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && paddr == `PIDR_OFF_DES_MID_REV)
         |-> prdata[7:4] == REVISION)
      else $error("revision code wrong");

   read_answer_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && psel && !penable && !pready) ##1 (clk_en && psel && penable)
         |-> pready)
      else $error("access phase not answered in one cycle");

   upper_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");

   write_error_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && pwrite) |-> pslverr && prdata == 32'h0000_0000)
      else $error("write not refused");

   reset_quiet_a: assert property (
      @(posedge pclk)
      !presetn
         |-> prdata == `PIDR_RDATA_RST && !pready && !pslverr)
      else $error("outputs not quiet in reset");

   ready_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && clk_en)
         |=> !pready)
      else $error("ready held past one cycle");

   err_with_ready_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pslverr
         |-> pready)
      else $error("error shown without ready");

   idle_data_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !pready
         |-> prdata == `PIDR_RDATA_RST)
      else $error("read data shown outside answer");

   enable_freeze_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !clk_en
         |=> $stable(pready) && $stable(pslverr) && $stable(prdata)
             && $stable(state))
      else $error("state moved with clock enable low");

   state_onehot_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
         |-> $onehot(state))
      else $error("state code not one-hot");

   ready_access_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready
         |-> state == pidr_pkg::PIDR_ACCESS)
      else $error("ready outside access state");

   setup_arms_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && take)
         |=> pready && state == pidr_pkg::PIDR_ACCESS)
      else $error("setup not answered");

   access_ends_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && state == pidr_pkg::PIDR_ACCESS)
         |=> state == pidr_pkg::PIDR_IDLE)
      else $error("access state not left");

   read_ok_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !pwrite && hit)
         |-> !pslverr && prdata[7:0] == id_byte)
      else $error("mapped read refused or wrong");

   unmapped_err_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pready && !hit)
         |-> pslverr && prdata == `PIDR_RDATA_RST)
      else $error("unmapped access not refused");

   hit_map_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
         |-> hit == (word_addr == `PIDR_OFF_SIZE_DES_HI
                     || word_addr == `PIDR_OFF_PART_LO
                     || word_addr == `PIDR_OFF_PART_HI_DES
                     || word_addr == `PIDR_OFF_DES_MID_REV))
      else $error("address map wrong");

   id_size_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (word_addr == `PIDR_OFF_SIZE_DES_HI)
         |-> id_byte[7:4] == `PIDR_SIZE_VAL)
      else $error("size nibble not zero");

   id_cont_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (word_addr == `PIDR_OFF_SIZE_DES_HI)
         |-> id_byte[3:0] == CONT_CODE)
      else $error("continuation nibble wrong");

   id_part_lo_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (word_addr == `PIDR_OFF_PART_LO)
         |-> id_byte == PART_NUM[7:0])
      else $error("part low byte wrong");

   id_part_hi_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (word_addr == `PIDR_OFF_PART_HI_DES)
         |-> id_byte[3:0] == PART_NUM[11:8])
      else $error("part high nibble wrong");

   id_des_lo_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (word_addr == `PIDR_OFF_PART_HI_DES)
         |-> id_byte[7:4] == DESIGNER[3:0])
      else $error("designer low nibble wrong");

   id_des_mid_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (word_addr == `PIDR_OFF_DES_MID_REV)
         |-> id_byte[2:0] == DESIGNER[6:4])
      else $error("designer middle bits wrong");

   id_flag_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (word_addr == `PIDR_OFF_DES_MID_REV)
         |-> id_byte[`PIDR_STD_FLAG_BIT] == 1'b1)
      else $error("standard flag bit clear");

   id_rev_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (word_addr == `PIDR_OFF_DES_MID_REV)
         |-> id_byte[7:4] == REVISION)
      else $error("revision nibble wrong");

   read_data_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && take && !pwrite)
         |=> prdata == {24'h00_0000, $past(id_byte)})
      else $error("read data not loaded");

   write_quiet_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && take && pwrite)
         |=> pslverr && prdata == `PIDR_RDATA_RST)
      else $error("write answered as a read");

   no_answer_idle_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !take)
         |=> !pready)
      else $error("ready without a setup cycle");

   no_wait_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable)
         |-> wait_cnt == 2'h0)
      else $error("access phase left waiting");

   miss_zero_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !hit
         |-> id_byte == 8'h00)
      else $error("unmapped byte not zero");

endmodule : pidr_regs

`default_nettype wire

// >>> hdl/pidr_params.svh
`ifndef PIDR_PARAMS_SVH
`define PIDR_PARAMS_SVH

// Register byte offsets inside the 4KB block
`define PIDR_OFF_SIZE_DES_HI   12'hFD0
`define PIDR_OFF_PART_LO       12'hFE0
`define PIDR_OFF_PART_HI_DES   12'hFE4
`define PIDR_OFF_DES_MID_REV   12'hFE8

// Field positions
`define PIDR_SIZE_MSB          7
`define PIDR_SIZE_LSB          4
`define PIDR_CONT_MSB          3
`define PIDR_CONT_LSB          0
`define PIDR_STD_FLAG_BIT      3

// Fixed field values
`define PIDR_SIZE_VAL          4'h0
`define PIDR_STD_FLAG_VAL      1'h1

// Identity defaults, arbitrary neutral values
`define PIDR_DEF_CONT          4'h0
`define PIDR_DEF_DESIGNER      7'h00
`define PIDR_DEF_PART          12'h000
`define PIDR_DEF_REVISION      4'h0

// Reset value of the read data register
`define PIDR_RDATA_RST         32'h0000_0000

`endif

// >>> hdl/pidr_pkg.sv
package pidr_pkg;

   typedef struct packed {
      logic [11:0] addr;
      logic        write;
      logic        sel;
      logic        enable;
   } pidr_req_s;

   typedef enum logic [1:0] {
      PIDR_IDLE   = 2'b01,
      PIDR_ACCESS = 2'b10
   } pidr_state_e;

endpackage : pidr_pkg

// >>> hdl/pidr_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "pidr_params.svh"

// Combinational address to identity byte lookup
module pidr_decode #(
   parameter logic [3:0]  CONT_CODE = `PIDR_DEF_CONT,
   parameter logic [6:0]  DESIGNER  = `PIDR_DEF_DESIGNER,
   parameter logic [11:0] PART_NUM  = `PIDR_DEF_PART,
   parameter logic [3:0]  REVISION  = `PIDR_DEF_REVISION
) (
   input  wire logic [11:0] addr,
   output logic      [7:0]  id_byte,
   output logic             hit
);

   always_comb begin
      id_byte = 8'h00;
      hit     = 1'b1;
      unique case (addr)
         `PIDR_OFF_SIZE_DES_HI: begin
            id_byte = {`PIDR_SIZE_VAL, CONT_CODE};
         end
         `PIDR_OFF_PART_LO: begin
            id_byte = PART_NUM[7:0];
         end
         `PIDR_OFF_PART_HI_DES: begin
            id_byte = {DESIGNER[3:0], PART_NUM[11:8]};
         end
         `PIDR_OFF_DES_MID_REV: begin
            id_byte = {REVISION, `PIDR_STD_FLAG_VAL, DESIGNER[6:4]};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

endmodule : pidr_decode

`default_nettype wire

// >>> tb/peripheral_identity_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module peripheral_identity_regs_tb;
   // Identity values are arbitrary
   localparam logic [3:0]  CONT    = 4'h5;
   localparam logic [6:0]  DES     = 7'h2A;
   localparam logic [11:0] PART    = 12'hC37;
   localparam logic [3:0]  REV     = 4'h6;
   localparam logic [31:0] V_SIZE  = {24'h0, 4'h0, CONT};
   localparam logic [31:0] V_LO    = {24'h0, PART[7:0]};
   localparam logic [31:0] V_HI    = {24'h0, DES[3:0], PART[11:8]};
   localparam logic [31:0] V_REV   = {24'h0, REV, 1'h1, DES[6:4]};

   logic        pclk;
   logic        presetn;
   logic        clk_en;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   int          err_count;
   int          checks_done;

   // Address, write, expected data, expected error
   logic [45:0] rows [10] = '{
      {12'hFD0, 1'h0, V_SIZE, 1'h0},
      {12'hFE0, 1'h0, V_LO, 1'h0},
      {12'hFE4, 1'h0, V_HI, 1'h0},
      {12'hFE8, 1'h0, V_REV, 1'h0},
      {12'hFE0, 1'h1, 32'h0, 1'h1},
      {12'hFE0, 1'h0, V_LO, 1'h0},
      {12'hFE8, 1'h1, 32'h0, 1'h1},
      {12'hFE8, 1'h0, V_REV, 1'h0},
      {12'hFEC, 1'h0, 32'h0, 1'h1},
      {12'hFD4, 1'h0, 32'h0, 1'h1}
   };

   pidr_regs #(
      .CONT_CODE (CONT),
      .DESIGNER  (DES),
      .PART_NUM  (PART),
      .REVISION  (REV)
   ) u_dut (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr)
   );

   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Entered right after a rising edge; leaves psel high
   task xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
             input logic e);
      int n;
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      check({31'h0, pready}, 32'h1);
      check(prdata, d);
      check({31'h0, pslverr}, {31'h0, e});
      penable <= 1'h0;
   endtask : xfer

   task results;
      $display("Mismatches %0d, checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   initial begin
      presetn = 1'h0;
      clk_en = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'hFFFF_FFFF;
      pstrb = 4'hF;
      err_count = 0;
      checks_done = 0;
      repeat (3) @(negedge pclk);
      check(prdata, 32'h0);
      check({30'h0, pready, pslverr}, 32'h0);
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
         xfer(rows[i][45:34], rows[i][33], rows[i][32:1], rows[i][0]);
      end
      // Setup held while the clock enable is low
      clk_en <= 1'h0;
      paddr <= 12'hFE4;
      pwrite <= 1'h0;
      repeat (3) begin
         @(negedge pclk);
         check({31'h0, pready}, 32'h0);
      end
      @(posedge pclk);
      clk_en <= 1'h1;
      xfer(12'hFE4, 1'h0, V_HI, 1'h0);
      // Reset in the access phase
      paddr <= 12'hFE8;
      @(posedge pclk);
      penable <= 1'h1;
      presetn <= 1'h0;
      @(negedge pclk);
      check(prdata, 32'h0);
      check({31'h0, pready}, 32'h0);
      @(posedge pclk);
      presetn <= 1'h1;
      penable <= 1'h0;
      psel <= 1'h0;
      @(posedge pclk);
      check({30'h0, pready, pslverr}, 32'h0);
      xfer(12'hFD0, 1'h0, V_SIZE, 1'h0);
      psel <= 1'h0;
      results();
   end

   initial begin
      repeat (2000) @(posedge pclk);
      err_count++;
      results();
   end
endmodule : peripheral_identity_regs_tb
`default_nettype wire
